/* File: rtl/emp_ext_mem_port.sv */
// Purpose: ext_mem_port control: pin ownership and strobe timing
// Assumes: core raises core_req only while core_busy is low
// Notes: pins trail the phase machine by one register stage

`timescale 1ns/1ps

// ****************************************************************
// top module
// ****************************************************************
module emp_ext_mem_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core external move request
  input wire logic core_req,
  input wire logic core_we,
  input wire logic [15:0] core_addr,
  input wire logic [7:0] core_wdata,
  output logic core_busy,
  output logic core_done,
  output logic core_offchip,
  output logic [7:0] core_rdata,
  // port 1: data, or address low and data when multiplexed
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p1_latch,
  input wire logic [7:0] p1_latch_oe,
  input wire logic [7:0] p1_push_pull,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  // port 2: address low when non-multiplexed
  input wire logic [7:0] p2_latch,
  input wire logic [7:0] p2_latch_oe,
  input wire logic [7:0] p2_push_pull,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe,
  // port 3: address high
  input wire logic [7:0] p3_latch,
  input wire logic [7:0] p3_latch_oe,
  input wire logic [7:0] p3_push_pull,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe,
  // control pins: bit 0 P0.0 latch strobe, bit 1 P4.4 read, bit 2 P4.5 write
  input wire logic [2:0] ctl_latch,
  input wire logic [2:0] ctl_latch_oe,
  input wire logic [2:0] ctl_push_pull,
  output logic [2:0] ctl_out,
  output logic [2:0] ctl_oe
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [15:0] ext_mem_config;
  logic [15:0] bus_timing;
  emp_pkg::emp_state_t state;
  emp_pkg::emp_state_t next_state;
  emp_pkg::emp_state_t after_latch;
  emp_pkg::emp_mode_t mem_mode;
  logic nonmux;
  logic [7:0] page;
  logic [1:0] addr_ctrl_setup;
  logic [3:0] strobe_pulse_width;
  logic [1:0] addr_ctrl_hold;
  logic [1:0] latch_high_time;
  logic [1:0] latch_low_time;
  logic offchip;
  logic accept;
  logic [15:0] addr_q;
  logic we_q;
  logic [7:0] wdata_q;
  logic rd_sample;
  logic ivl_load;
  logic [3:0] ivl_val;
  logic ivl_last;
  logic active;
  logic in_latch;
  logic in_access;
  logic in_strobe;
  logic [7:0] upper_addr;
  logic [7:0] p1_val;
  logic [7:0] p1_drive;
  logic [2:0] ctl_val;
  logic [2:0] ctl_claim;
  logic setup_phase;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rd_mux;

  // ****************************************************************
  // field decode
  // ****************************************************************
  // page, mux and mode bits share one register
  assign mem_mode = emp_pkg::emp_mode_t'(ext_mem_config[emp_pkg::CFG_MODE_LSB +: 2]);
  assign nonmux = ext_mem_config[emp_pkg::CFG_NONMUX_BIT];
  assign page = ext_mem_config[emp_pkg::CFG_PAGE_LSB +: 8];
  // every interval is a count of core clock periods
  assign addr_ctrl_setup = bus_timing[emp_pkg::TIM_ACS_LSB +: 2];
  assign strobe_pulse_width = bus_timing[emp_pkg::TIM_ACW_LSB +: 4];
  assign addr_ctrl_hold = bus_timing[emp_pkg::TIM_ACH_LSB +: 2];
  assign latch_high_time = bus_timing[emp_pkg::TIM_ALEH_LSB +: 2];
  assign latch_low_time = bus_timing[emp_pkg::TIM_ALEL_LSB +: 2];

  // ****************************************************************
  // apb slave
  // ****************************************************************
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb,
                                             input logic [15:0] mask);
    logic [15:0] merged;
    merged = old;
    if (strb[0]) begin
      merged[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = wd[15:8];
    end
    return merged & mask;
  endfunction

  assign setup_phase = psel && !penable;
  // pready is high only in the single access cycle, so this fires once
  assign wr_en = psel && penable && pready && pwrite;
  assign addr_hit = (paddr == emp_pkg::OFS_CONFIG) || (paddr == emp_pkg::OFS_TIMING) ||
                    (paddr == emp_pkg::OFS_STATUS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      emp_pkg::OFS_CONFIG: begin
        rd_mux[15:0] = ext_mem_config;
      end
      emp_pkg::OFS_TIMING: begin
        rd_mux[15:0] = bus_timing;
      end
      emp_pkg::OFS_STATUS: begin
        rd_mux[emp_pkg::STA_BUSY_BIT] = (state != emp_pkg::ST_IDLE);
        rd_mux[emp_pkg::STA_CLAIM_BIT] = active;
        rd_mux[emp_pkg::STA_RDATA_LSB +: 8] = core_rdata;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        pslverr <= !addr_hit;
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_mem_config <= emp_pkg::CONFIG_RST;
      bus_timing <= emp_pkg::TIMING_RST;
    end else if (wr_en) begin
      // mux select and four memory maps
      if (paddr == emp_pkg::OFS_CONFIG) begin
        ext_mem_config <= lane_merge(ext_mem_config, pwdata, pstrb, emp_pkg::CFG_MASK);
      end
      // setup, pulse and hold ranges fixed by field width
      if (paddr == emp_pkg::OFS_TIMING) begin
        bus_timing <= lane_merge(bus_timing, pwdata, pstrb, emp_pkg::TIM_MASK);
      end
    end
  end

  // ****************************************************************
  // request acceptance
  // ****************************************************************
  always_comb begin
    case (mem_mode)
      emp_pkg::EMP_ONCHIP: offchip = 1'b0;
      emp_pkg::EMP_OFFCHIP: offchip = 1'b1;
      default: offchip = (core_addr >= emp_pkg::ONCHIP_LIMIT);
    endcase
  end

  assign accept = (state == emp_pkg::ST_IDLE) && core_req;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      addr_q <= 16'h0000;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
    end else if (accept && offchip) begin
      addr_q <= core_addr;
      we_q <= core_we;
      wdata_q <= core_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      core_busy <= 1'b0;
      core_done <= 1'b0;
      core_offchip <= 1'b0;
    end else begin
      core_busy <= (next_state != emp_pkg::ST_IDLE);
      core_done <= (state == emp_pkg::ST_DONE) || (accept && !offchip);
      if (accept) begin
        core_offchip <= offchip;
      end
    end
  end

  // ****************************************************************
  // phase machine
  // ****************************************************************
  // zero setup skips the setup phase altogether
  assign after_latch = (addr_ctrl_setup != 2'h0) ? emp_pkg::ST_SETUP : emp_pkg::ST_STROBE;

  always_comb begin
    next_state = state;
    case (state)
      emp_pkg::ST_IDLE: begin
        // only off-chip moves start a bus cycle
        if (accept && offchip) begin
          next_state = nonmux ? after_latch : emp_pkg::ST_ALE_HI;
        end
      end
      emp_pkg::ST_ALE_HI: begin
        if (ivl_last) begin
          next_state = emp_pkg::ST_ALE_LO;
        end
      end
      emp_pkg::ST_ALE_LO: begin
        if (ivl_last) begin
          next_state = after_latch;
        end
      end
      emp_pkg::ST_SETUP: begin
        if (ivl_last) begin
          next_state = emp_pkg::ST_STROBE;
        end
      end
      emp_pkg::ST_STROBE: begin
        if (ivl_last) begin
          next_state = (addr_ctrl_hold != 2'h0) ? emp_pkg::ST_HOLD : emp_pkg::ST_DONE;
        end
      end
      emp_pkg::ST_HOLD: begin
        if (ivl_last) begin
          next_state = emp_pkg::ST_DONE;
        end
      end
      emp_pkg::ST_DONE: begin
        next_state = emp_pkg::ST_IDLE;
      end
      default: begin
        next_state = emp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= emp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // interval loaded on phase entry as duration minus one
  assign ivl_load = (next_state != state);

  always_comb begin
    case (next_state)
      emp_pkg::ST_ALE_HI: ivl_val = {2'h0, latch_high_time};
      emp_pkg::ST_ALE_LO: ivl_val = {2'h0, latch_low_time};
      emp_pkg::ST_SETUP: ivl_val = {2'h0, addr_ctrl_setup - 2'h1};
      emp_pkg::ST_STROBE: ivl_val = strobe_pulse_width;
      emp_pkg::ST_HOLD: ivl_val = {2'h0, addr_ctrl_hold - 2'h1};
      default: ivl_val = 4'h0;
    endcase
  end

  emp_interval u_interval (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(ivl_load),
    .load_val(ivl_val),
    .last(ivl_last)
  );

  // read data taken on the edge that ends the strobe at the pins
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rd_sample <= 1'b0;
      core_rdata <= 8'h00;
    end else begin
      rd_sample <= (state == emp_pkg::ST_STROBE) && ivl_last && !we_q;
      if (rd_sample) begin
        core_rdata <= p1_in;
      end
    end
  end

  // ****************************************************************
  // bus pin values
  // ****************************************************************
  // done state already gives the pins back
  assign active = (state != emp_pkg::ST_IDLE) && (state != emp_pkg::ST_DONE);
  assign in_latch = (state == emp_pkg::ST_ALE_HI) || (state == emp_pkg::ST_ALE_LO);
  assign in_strobe = (state == emp_pkg::ST_STROBE);
  assign in_access = (state == emp_pkg::ST_SETUP) || in_strobe || (state == emp_pkg::ST_HOLD);
  // only the non-banked split map takes the high byte from the page field, all other maps from the move
  assign upper_addr = (mem_mode == emp_pkg::EMP_SPLIT_NOBANK) ? page : addr_q[15:8];

  always_comb begin
    p1_val = in_latch ? addr_q[7:0] : wdata_q;
    // write data spans setup, strobe and hold
    // data lines float while they are inputs of a read
    p1_drive = (in_latch || (in_access && we_q)) ? 8'hff : 8'h00;
  end

  always_comb begin
    ctl_val = 3'h7;
    ctl_val[emp_pkg::CTL_ALE] = (state == emp_pkg::ST_ALE_HI);
    ctl_val[emp_pkg::CTL_RD] = !(in_strobe && !we_q);
    ctl_val[emp_pkg::CTL_WR] = !(in_strobe && we_q);
    ctl_claim = {3{active}};
    // latch strobe pin is only taken in multiplexed cycles
    ctl_claim[emp_pkg::CTL_ALE] = active && !nonmux;
  end

  // ****************************************************************
  // pin ownership
  // ****************************************************************
  // ownership muxed here, output mode applied per pin
  emp_pin_mux #(.W(8)) u_port1 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .claim({8{active}}),
    .bus_val(p1_val),
    .bus_drive(p1_drive),
    .latch_val(p1_latch),
    .latch_drive(p1_latch_oe),
    .push_pull(p1_push_pull),
    .pin_out(p1_out),
    .pin_oe(p1_oe)
  );

  emp_pin_mux #(.W(8)) u_port2 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .claim({8{active && nonmux}}),
    .bus_val(addr_q[7:0]),
    .bus_drive(8'hff),
    .latch_val(p2_latch),
    .latch_drive(p2_latch_oe),
    .push_pull(p2_push_pull),
    .pin_out(p2_out),
    .pin_oe(p2_oe)
  );

  emp_pin_mux #(.W(8)) u_port3 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .claim({8{active}}),
    .bus_val(upper_addr),
    .bus_drive(8'hff),
    .latch_val(p3_latch),
    .latch_drive(p3_latch_oe),
    .push_pull(p3_push_pull),
    .pin_out(p3_out),
    .pin_oe(p3_oe)
  );

  // strobes pass the same ownership mux and output register as the port pins
  emp_pin_mux #(.W(3)) u_ctl (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .claim(ctl_claim),
    .bus_val(ctl_val),
    .bus_drive(3'h7),
    .latch_val(ctl_latch),
    .latch_drive(ctl_latch_oe),
    .push_pull(ctl_push_pull),
    .pin_out(ctl_out),
    .pin_oe(ctl_oe)
  );

endmodule

/* File: rtl/emp_pkg.sv */
// Purpose: shared constants and types of the external memory port
// Assumes: APB register map with one aligned 32-bit word per register
// Notes: intervals are counted in core clock periods

// ****************************************************************
// constants and types
// ****************************************************************
package emp_pkg;
  // register byte addresses
  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_TIMING = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;

  // ext_mem_config layout
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_NONMUX_BIT = 4;
  localparam int CFG_PAGE_LSB = 8;
  localparam logic [15:0] CFG_MASK = 16'hff1c;
  localparam logic [15:0] CONFIG_RST = 16'h0000;

  // timing register layout; widths and latch times hold duration minus one
  localparam int TIM_ACS_LSB = 0;
  localparam int TIM_ACW_LSB = 4;
  localparam int TIM_ACH_LSB = 8;
  localparam int TIM_ALEH_LSB = 12;
  localparam int TIM_ALEL_LSB = 14;
  localparam logic [15:0] TIM_MASK = 16'hf3f3;
  localparam logic [15:0] TIMING_RST = 16'hf3f3;

  // status layout
  localparam int STA_BUSY_BIT = 0;
  localparam int STA_CLAIM_BIT = 1;
  localparam int STA_RDATA_LSB = 8;

  // control pin positions: latch strobe, read strobe, write strobe
  localparam int CTL_ALE = 0;
  localparam int CTL_RD = 1;
  localparam int CTL_WR = 2;

  // first address that lies off-chip in the split maps
  localparam logic [15:0] ONCHIP_LIMIT = 16'h0400;

  typedef enum logic [1:0] {
    EMP_ONCHIP = 2'h0,
    EMP_SPLIT_NOBANK = 2'h1,
    EMP_SPLIT_BANK = 2'h2,
    EMP_OFFCHIP = 2'h3
  } emp_mode_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ALE_HI = 7'h02,
    ST_ALE_LO = 7'h04,
    ST_SETUP = 7'h08,
    ST_STROBE = 7'h10,
    ST_HOLD = 7'h20,
    ST_DONE = 7'h40
  } emp_state_t;
endpackage

/* File: rtl/emp_interval.sv */
// Purpose: down counter that times one bus phase
// Assumes: loaded with duration minus one on phase entry
// Notes: last is high in the final cycle of the phase

`timescale 1ns/1ps

// ****************************************************************
// phase interval counter
// ****************************************************************
module emp_interval (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic load,
  input wire logic [3:0] load_val,
  // status
  output logic last
);
  logic [3:0] count;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count <= 4'h0;
    end else if (load) begin
      count <= load_val;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end

  assign last = (count == 4'h0);
endmodule

/* File: rtl/emp_pin_mux.sv */
// Purpose: hands a group of port pins to the bus or back to the port
// Assumes: latch_val and latch_drive come from port latch or crossbar
// Notes: output mode is applied after the ownership choice

`timescale 1ns/1ps

// ****************************************************************
// pin ownership and output mode
// ****************************************************************
module emp_pin_mux #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bus side
  input wire logic [W-1:0] claim,
  input wire logic [W-1:0] bus_val,
  input wire logic [W-1:0] bus_drive,
  // port side
  input wire logic [W-1:0] latch_val,
  input wire logic [W-1:0] latch_drive,
  input wire logic [W-1:0] push_pull,
  // pins
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe
);
  logic [W-1:0] next_out;
  logic [W-1:0] next_drive;

  always_comb begin
    next_out = (claim & bus_val) | (~claim & latch_val);
    next_drive = (claim & bus_drive) | (~claim & latch_drive);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_out <= '1;
      pin_oe <= '0;
    end else begin
      pin_out <= next_out;
      // open-drain pins only pull low, whoever owns them
      pin_oe <= next_drive & (push_pull | ~next_out);
    end
  end
endmodule

/* File: verification/emp_ext_mem_port_sva.sv */
// Purpose: concurrent checks on pin ownership, strobe timing and handshakes
// Assumes: control pin port-side enables stay low while moves run
// Notes: pins lag the phase machine by one cycle
`timescale 1ns/1ps
// ****************************************************************
// checker
// ****************************************************************
module emp_ext_mem_port_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // handshakes
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic core_req,
  input wire logic core_busy,
  input wire logic core_done,
  // pins
  input wire logic [7:0] p1_latch,
  input wire logic [7:0] p1_latch_oe,
  input wire logic [7:0] p1_push_pull,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] p3_latch,
  input wire logic [7:0] p3_out,
  input wire logic [2:0] ctl_latch_oe,
  input wire logic [2:0] ctl_out,
  input wire logic [2:0] ctl_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence ale_up_s;
    $rose(ctl_oe[0]) && ctl_out[0];
  endsequence
  sequence wr_held_s;
    !ctl_out[2] ##1 !ctl_out[2];
  endsequence
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("register access not answered in one cycle");
  idle_pins_a: assert property ($past(rst_b) && !core_busy
    |-> p1_out == $past(p1_latch) && p3_out == $past(p3_latch)
    && p1_oe == ($past(p1_latch_oe) & ($past(p1_push_pull) | ~$past(p1_latch))))
    else $error("idle pins do not follow the port latches");
  claim_busy_a: assert property (ctl_oe[1] && !$past(ctl_latch_oe[1]) |-> core_busy)
    else $error("read strobe driven outside a move");
  take_answer_a: assert property (core_req && !core_busy && !core_done
    |=> core_done != core_busy)
    else $error("accepted move neither finished nor started");
  move_bound_a: assert property ($rose(core_busy) |-> ##[2:31] core_done)
    else $error("off-chip move outlasts the slowest timing");
  busy_done_a: assert property ($fell(core_busy) |-> core_done)
    else $error("busy dropped without completion");
  ale_high_a: assert property (ale_up_s |-> ##[1:4] $fell(ctl_out[0]))
    else $error("latch strobe high time out of range");
  ale_low_a: assert property ($fell(ctl_out[0]) && core_busy
    |-> ##[1:7] ($fell(ctl_out[1]) || $fell(ctl_out[2])))
    else $error("latch strobe low phase out of range");
  wr_width_a: assert property ($fell(ctl_out[2]) && core_busy |-> ##[1:16] $rose(ctl_out[2]))
    else $error("write strobe width out of range");
  wr_data_a: assert property (wr_held_s |-> $stable(p1_out)
    && p1_oe == (p1_push_pull | ~p1_out))
    else $error("write data not held during the strobe");
  rd_float_a: assert property (!ctl_out[1] |-> p1_oe == 8'h00)
    else $error("data drivers on during a read strobe");
endmodule

/* File: verification/emp_mem_model.sv */
// Purpose: off-chip byte memory on the external bus pins
// Assumes: strobes active low, latch strobe active high
// Notes: answers within the strobe; no wait states
`timescale 1ns/1ps
// ****************************************************************
// memory model
// ****************************************************************
module emp_mem_model (
  // clock
  input wire logic sys_clk,
  // bus pins
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p3_out,
  input wire logic [2:0] ctl_out,
  input wire logic [2:0] ctl_oe,
  // read data
  output logic [7:0] p1_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_lo;
  logic [7:0] last = 8'h00;
  logic [15:0] adr;
  // low address from the latch only when the latch strobe pin is claimed
  assign adr = {p3_out, ctl_oe[0] ? lat_lo : p2_out};
  always @(posedge sys_clk) begin
    if (ctl_oe[0] && ctl_out[0]) lat_lo <= p1_out;
    if (!ctl_out[2]) mem[adr] <= p1_out;
    if (!ctl_out[1]) last <= p1_in;
  end
  // released data lines show the inverse, so a stale copy cannot pass
  assign p1_in = !ctl_out[1] ? mem[adr] : ~last;
endmodule

/* File: verification/test_emp_ext_mem_port.sv */
// Purpose: register, move timing and pin release tests of the port
// Assumes: zero wait state register bus, one byte per move
// Notes: move length counted from the accept edge to completion
`timescale 1ns/1ps
module test_emp_ext_mem_port;
  typedef struct {logic [15:0] cfg; logic [15:0] tim; logic we;
    logic [15:0] adr; logic [7:0] dat; int cyc;} emp_case_t;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, slv, off;
  logic core_req, core_we, core_busy, core_done, core_offchip;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] core_addr;
  logic [7:0] core_wdata, core_rdata, rb, p1_in, p1_latch, p1_latch_oe, p1_push_pull;
  logic [7:0] p1_out, p1_oe, p2_latch, p2_latch_oe, p2_push_pull, p2_out, p2_oe;
  logic [7:0] p3_latch, p3_latch_oe, p3_push_pull, p3_out, p3_oe;
  logic [2:0] ctl_latch, ctl_latch_oe, ctl_push_pull, ctl_out, ctl_oe;
  int err_total = 0;
  int cmp_count = 0;
  int cyc_count = 0;
  int n;
  emp_case_t tbl [9] = '{
    '{16'h000c, 16'h0000, 1'b1, 16'h1234, 8'ha5, 5},
    '{16'h001c, 16'h0111, 1'b0, 16'h1234, 8'ha5, 6},
    '{16'h000c, 16'hf3f3, 1'b1, 16'h2345, 8'h3c, 32},
    '{16'h001c, 16'h0000, 1'b0, 16'h2345, 8'h3c, 3},
    '{16'h1204, 16'h0000, 1'b1, 16'h0534, 8'hc3, 5},
    '{16'h0018, 16'h0000, 1'b0, 16'h1234, 8'hc3, 3},
    '{16'h0018, 16'h0000, 1'b0, 16'h03ff, 8'hc3, 1},
    '{16'h0000, 16'h0000, 1'b1, 16'h8000, 8'h77, 1},
    '{16'h1204, 16'h0000, 1'b0, 16'h0634, 8'hc3, 5}};
  emp_ext_mem_port dut_u (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .core_req, .core_we, .core_addr, .core_wdata,
    .core_busy, .core_done, .core_offchip, .core_rdata, .p1_in, .p1_latch, .p1_latch_oe,
    .p1_push_pull, .p1_out, .p1_oe, .p2_latch, .p2_latch_oe, .p2_push_pull, .p2_out, .p2_oe,
    .p3_latch, .p3_latch_oe, .p3_push_pull, .p3_out, .p3_oe, .ctl_latch, .ctl_latch_oe,
    .ctl_push_pull, .ctl_out, .ctl_oe);
  emp_mem_model mem_u (.sys_clk, .p1_out, .p2_out, .p3_out, .ctl_out, .ctl_oe, .p1_in);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // a hang ends the run through the same closing report
  always @(posedge sys_clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 6000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic move(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    core_req <= 1'b1;
    core_we <= w;
    core_addr <= a;
    core_wdata <= d;
    @(posedge sys_clk);
    core_req <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (core_done !== 1'b1);
    rb = core_rdata;
    off = core_offchip;
  endtask
  // bus pins parked on the given port latch values, port-side enables and output modes
  task automatic park(input logic [7:0] v, input logic [7:0] oe, input logic [7:0] pp,
    input logic [2:0] cv, input logic [2:0] cp);
    p1_latch <= v;
    p2_latch <= v;
    p3_latch <= v;
    ctl_latch <= cv;
    p1_latch_oe <= oe;
    p2_latch_oe <= oe;
    p3_latch_oe <= oe;
    ctl_latch_oe <= oe[2:0];
    p1_push_pull <= pp;
    p2_push_pull <= pp;
    p3_push_pull <= pp;
    ctl_push_pull <= cp;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {core_req, core_we, core_addr, core_wdata} = '0;
    park(8'hff, 8'h00, 8'hff, 3'h7, 3'h7);
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, emp_pkg::OFS_CONFIG, 32'h0, 4'hf);
    chk(rd, {16'h0000, emp_pkg::CONFIG_RST});
    apb(1'b0, emp_pkg::OFS_TIMING, 32'h0, 4'hf);
    chk(rd, {16'h0000, emp_pkg::TIMING_RST});
    apb(1'b0, 12'h00c, 32'h0, 4'hf);
    chk({rd[30:0], slv}, 32'h0000_0001);
    apb(1'b1, emp_pkg::OFS_CONFIG, 32'hffff_ffff, 4'h2);
    apb(1'b0, emp_pkg::OFS_CONFIG, 32'h0, 4'hf);
    chk(rd, 32'h0000_ff00);
    apb(1'b1, emp_pkg::OFS_CONFIG, 32'hffff_ffff, 4'hf);
    apb(1'b0, emp_pkg::OFS_CONFIG, 32'h0, 4'hf);
    chk(rd, {16'h0000, emp_pkg::CFG_MASK});
    apb(1'b1, emp_pkg::OFS_STATUS, 32'hffff_ffff, 4'hf);
    apb(1'b0, emp_pkg::OFS_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h0000_0000);
    foreach (tbl[i]) begin
      apb(1'b1, emp_pkg::OFS_CONFIG, {16'h0000, tbl[i].cfg}, 4'hf);
      apb(1'b1, emp_pkg::OFS_TIMING, {16'h0000, tbl[i].tim}, 4'hf);
      move(tbl[i].we, tbl[i].adr, tbl[i].dat);
      chk(n, tbl[i].cyc);
      chk(off, tbl[i].cyc != 1);
      if (!tbl[i].we) chk(rb, tbl[i].dat);
    end
    @(posedge sys_clk);
    park(8'h5a, 8'hff, 8'h0f, 3'b110, 3'b001);
    repeat (2) @(posedge sys_clk);
    chk(p1_out, 8'h5a);
    chk(p2_out, 8'h5a);
    chk(p1_oe, 8'haf);
    chk(ctl_out, 3'b110);
    chk(ctl_oe, 3'b001);
    chk(p3_out, 8'h5a);
    chk({p2_oe, p3_oe}, 16'hafaf);
    park(8'hff, 8'h00, 8'hff, 3'h7, 3'h7);
    repeat (2) @(posedge sys_clk);
    final_report();
  end
endmodule
bind emp_ext_mem_port emp_ext_mem_port_sva sva_u (.sys_clk, .rst_b, .psel, .penable, .pready,
  .core_req, .core_busy, .core_done, .p1_latch, .p1_latch_oe, .p1_push_pull, .p1_out, .p1_oe,
  .p3_latch, .p3_out, .ctl_latch_oe, .ctl_out, .ctl_oe);
